// ---- design/hue_pkg.sv ----
package hue_pkg;
	// host register offsets (3-bit host address)
	localparam logic [2:0] HOST_DATA   = 3'h0;
	localparam logic [2:0] HOST_IER    = 3'h1;
	localparam logic [2:0] HOST_FIFO   = 3'h2;
	localparam logic [2:0] HOST_LINE   = 3'h3;
	localparam logic [2:0] HOST_LSTAT  = 3'h5;
	localparam logic [2:0] HOST_MSTAT  = 3'h6;
	localparam logic [2:0] HOST_SCR    = 3'h7;
	// mpu register offsets (low address byte)
	localparam logic [7:0] MPU_TWEAKS  = 8'he9;
	localparam logic [7:0] MPU_SYSCFG  = 8'hef;
	localparam logic [7:0] MPU_FIFO    = 8'hf2;
	localparam logic [7:0] MPU_RXBUF   = 8'hf0;
	localparam logic [7:0] MPU_TXHOLD  = 8'hf1;
	localparam logic [7:0] MPU_MSTAT   = 8'hf6;
	localparam logic [7:0] MPU_SCR     = 8'hf7;
	localparam logic [7:0] MPU_DIVLO   = 8'hf8;
	localparam logic [7:0] MPU_DIVHI   = 8'hf9;
	localparam logic [7:0] MPU_EVENTS  = 8'hfa;
	// field positions
	localparam int FC_ENABLE  = 0;
	localparam int FC_RXRST   = 1;
	localparam int FC_TXRST   = 2;
	localparam int FC_DMA     = 3;
	localparam int FC_TXOVR   = 4;
	localparam int FC_CHANGE  = 5;
	localparam int LC_DIVACC  = 7;
	localparam int MT_CHAIN   = 0;
	localparam int MT_OVRWR   = 1;
	localparam int SC_HOSTMODE = 1;
	localparam int SC_FORCEOFF = 3;
	localparam int FIFO_DEPTH  = 16;
	// trigger levels
	localparam logic [4:0] TRIG_1  = 5'h01;
	localparam logic [4:0] TRIG_4  = 5'h04;
	localparam logic [4:0] TRIG_8  = 5'h08;
	localparam logic [4:0] TRIG_14 = 5'h0e;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int UNMAPPED_READ = 8'hff;
endpackage

// ---- design/hue_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
// change detector on the four modem input bits
module hue_edge
	import hue_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire logic [3:0] level_i,
	output logic      [3:0] toggled_o,
	output logic      [3:0] falling_o
);
	logic [3:0] prev;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev <= 4'h0;
		end else begin
			prev <= level_i;
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_bit
		assign toggled_o[i] = prev[i] ^ level_i[i];
		assign falling_o[i] = prev[i] & ~level_i[i];
	end
endmodule
`default_nettype wire

// ---- design/hue_regs.sv ----
// Functional notes
// - host rx interrupt at selected trigger level
// - mpu fifo view flags change and overrun
// - mpu fifo read clears bits five, four
// - bit three selects dma mode one
// - bit two resets transmit fifo, self-clears
// - bit one resets receive fifo, self-clears
// - reset shadow flags clear on mpu read
// - host fifo write needs enable bit set
// - enable change by host write flushes data and interrupts
// - mpu can force fifo mode off
// - overrun modification overwrites last fifo slot
// - without modification, overrun writes ignored
// - fast chain mode drops enable on interrupt
// - slow chain mode drops after acknowledge
// - deltas on carrier, ready, clear changes
// - ring falling edge sets bit two
// - host modem status read clears deltas
// - scratch host rw, mpu ro, no interrupt
// - divisor latches interrupt mpu on write
// - rx interrupt within two clocks of byte
// - host pins live only in mode one
`timescale 1ns/1ps
`default_nettype none
module hue_regs
	import hue_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	// host parallel port
	input  wire logic [2:0] host_addr_i,
	input  wire logic       host_select_n_i,
	input  wire logic       host_read_strobe_n_i,
	input  wire logic       host_write_strobe_n_i,
	input  wire logic [7:0] host_data_bus_i,
	output logic      [7:0] host_data_bus_o,
	output logic            host_data_bus_oe_o,
	output logic            host_intr_o,
	// mpu register port
	input  wire logic [7:0] mpu_addr_i,
	input  wire logic       mpu_rd_i,
	input  wire logic       mpu_wr_i,
	input  wire logic [7:0] mpu_wdata_i,
	output logic      [7:0] mpu_rdata_o,
	output logic            mpu_intr_o,
	output logic            dma_mode_o,
	// daisy chain
	input  wire logic       chain_enable_in_i,
	input  wire logic       interrupt_acknowledge_cycle_i,
	output logic            chain_enable_out_o
);
	localparam int AW = $clog2(DEPTH);

	// ****************
	// state
	// ****************
	typedef struct packed {
		logic [2:0]       s_rd;
		logic [2:0]       s_wr;
		logic [2:0]       s_cs;
		logic [7:0]       fifo_ctl;
		logic [1:0]       rst_shadow;
		logic             chg_flag;
		logic             txovr_flag;
		logic [7:0]       line_ctl;
		logic [7:0]       ier;
		logic [7:0]       div_lo;
		logic [7:0]       div_hi;
		logic [7:0]       scratch;
		logic [7:0]       msr;
		logic [1:0]       tweaks;
		logic [7:0]       syscfg;
		logic [DEPTH-1:0][7:0] rx_mem;
		logic [AW:0]      rx_cnt;
		logic [7:0]       tx_hold;
		logic             tx_full;
		logic             div_evt;
		logic             overrun;
		logic             chain;
		logic [7:0]       host_q;
		logic [7:0]       mpu_q;
	} hue_regs_s;

	hue_regs_s r;
	hue_regs_s next_r;

	// ****************
	// edge sensing
	// ****************
	logic [3:0] m_tog;
	logic [3:0] m_fall;
	logic       hrd_pulse;
	logic       hwr_pulse;
	logic       hsel;
	logic [4:0] trig;
	logic       rx_int;
	logic [2:0] hstrobe_rd;
	logic [2:0] hstrobe_wr;

	hue_edge u_edge (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.level_i   (r.msr[7:4]),
		.toggled_o (m_tog),
		.falling_o (m_fall)
	);

	// host pins qualified by mode one
	// select is taken one stage earlier than the strobe edge pair, so both are
	// seen together when select and strobe fall on the same clock
	assign hsel = ~r.s_cs[1] & r.syscfg[SC_HOSTMODE];
	assign hstrobe_rd = r.s_rd;
	assign hstrobe_wr = r.s_wr;
	assign hrd_pulse = hsel & hstrobe_rd[2] & ~hstrobe_rd[1];
	assign hwr_pulse = hsel & hstrobe_wr[2] & ~hstrobe_wr[1];

	always_comb begin
		unique case (r.fifo_ctl[7:6])
			2'b00: trig = TRIG_1;
			2'b01: trig = TRIG_4;
			2'b10: trig = TRIG_8;
			2'b11: trig = TRIG_14;
		endcase
	end

	// interrupt asserts from fill level directly
	assign rx_int = r.ier[0] &
		(r.fifo_ctl[FC_ENABLE] ? ({1'b0, r.rx_cnt} >= {{(5 - AW) {1'b0}}, trig} ? 1'b1 : 1'b0)
			: (r.rx_cnt != '0));

	// ****************
	// next state
	// ****************
	always_comb begin
		logic [7:0] hw;
		logic       en_new;
		hw = host_data_bus_i;
		en_new = 1'b0;
		next_r = r;
		// stage 0 is only read by stage 1
		next_r.s_rd = {r.s_rd[1], r.s_rd[0], host_read_strobe_n_i};
		next_r.s_wr = {r.s_wr[1], r.s_wr[0], host_write_strobe_n_i};
		next_r.s_cs = {r.s_cs[1], r.s_cs[0], host_select_n_i};
		next_r.fifo_ctl[FC_TXRST] = 1'b0;
		next_r.fifo_ctl[FC_RXRST] = 1'b0;
		next_r.div_evt = 1'b0;

		// ---- host reads
		if (hrd_pulse) begin
			unique case (host_addr_i)
				HOST_DATA: begin
					if (r.line_ctl[LC_DIVACC]) begin
						next_r.host_q = r.div_lo;
					end else begin
						next_r.host_q = r.rx_mem[0];
						if (r.rx_cnt != '0) begin
							next_r.rx_mem = r.rx_mem >> 8;
							next_r.rx_cnt = r.rx_cnt - 1'b1;
						end
						next_r.overrun = 1'b0;
					end
				end
				HOST_IER:   next_r.host_q = r.line_ctl[LC_DIVACC] ? r.div_hi : r.ier;
				HOST_FIFO:  next_r.host_q = {~rx_int, 7'h00};
				HOST_LINE:  next_r.host_q = r.line_ctl;
				HOST_LSTAT: begin
					next_r.host_q = {6'h00, r.overrun, r.rx_cnt != '0};
					next_r.overrun = 1'b0;
				end
				HOST_MSTAT: begin
					next_r.host_q = r.msr;
					next_r.msr[3:0] = 4'h0;
				end
				HOST_SCR:   next_r.host_q = r.scratch;
				default:    next_r.host_q = RESET_BYTE;
			endcase
		end

		// ---- host writes
		if (hwr_pulse) begin
			unique case (host_addr_i)
				HOST_DATA: begin
					if (r.line_ctl[LC_DIVACC]) begin
						next_r.div_lo = hw;
						next_r.div_evt = 1'b1;
					end else if (r.tx_full) begin
						next_r.txovr_flag = 1'b1;
					end else begin
						next_r.tx_hold = hw;
						next_r.tx_full = 1'b1;
					end
				end
				HOST_IER: begin
					if (r.line_ctl[LC_DIVACC]) begin
						next_r.div_hi = hw;
						next_r.div_evt = 1'b1;
					end else begin
						next_r.ier = hw;
					end
				end
				HOST_FIFO: begin
					en_new = hw[FC_ENABLE] & ~r.syscfg[SC_FORCEOFF];
					if (en_new) begin
						next_r.fifo_ctl = {hw[7:6], 2'b00, hw[FC_DMA], hw[2:1], 1'b1};
						next_r.rst_shadow = r.rst_shadow | hw[2:1];
					end else begin
						next_r.fifo_ctl[FC_ENABLE] = 1'b0;
					end
					next_r.chg_flag = 1'b1;
				end
				HOST_LINE: next_r.line_ctl = hw;
				HOST_SCR:  next_r.scratch = hw;
				default: ;
			endcase
		end

		// ---- mpu writes
		if (mpu_wr_i) begin
			unique case (mpu_addr_i)
				MPU_TWEAKS: next_r.tweaks = mpu_wdata_i[1:0];
				MPU_SYSCFG: next_r.syscfg = mpu_wdata_i;
				MPU_MSTAT:  next_r.msr[7:4] = mpu_wdata_i[7:4];
				MPU_RXBUF: begin
					if (next_r.rx_cnt < (AW + 1)'(DEPTH)) begin
						next_r.rx_mem[next_r.rx_cnt[AW-1:0]] = mpu_wdata_i;
						next_r.rx_cnt = next_r.rx_cnt + 1'b1;
					end else if (r.tweaks[MT_OVRWR]) begin
						next_r.rx_mem[DEPTH-1] = mpu_wdata_i;
						next_r.overrun = 1'b1;
					end else begin
						next_r.overrun = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (mpu_rd_i) begin
			unique case (mpu_addr_i)
				MPU_TXHOLD: next_r.tx_full = 1'b0;
				MPU_FIFO: begin
					next_r.chg_flag = 1'b0;
					next_r.txovr_flag = 1'b0;
					next_r.rst_shadow = 2'b00;
				end
				default: ;
			endcase
		end
		// flags set after the clear so set wins
		if (hwr_pulse && host_addr_i == HOST_FIFO) begin
			next_r.chg_flag = 1'b1;
			if (en_new) begin
				next_r.rst_shadow = next_r.rst_shadow | hw[2:1];
			end
		end
		if (hwr_pulse && host_addr_i == HOST_DATA && !r.line_ctl[LC_DIVACC] && r.tx_full) begin
			next_r.txovr_flag = 1'b1;
		end

		next_r.msr[3] = next_r.msr[3] | m_tog[3];
		next_r.msr[1] = next_r.msr[1] | m_tog[1];
		next_r.msr[0] = next_r.msr[0] | m_tog[0];
		next_r.msr[2] = next_r.msr[2] | m_fall[2];

		if (next_r.fifo_ctl[FC_TXRST]) begin
			next_r.tx_full = 1'b0;
		end
		if (next_r.fifo_ctl[FC_RXRST]) begin
			next_r.rx_cnt = '0;
		end
		// enable change flushes and drops interrupts
		if (next_r.fifo_ctl[FC_ENABLE] != r.fifo_ctl[FC_ENABLE]) begin
			next_r.rx_cnt = '0;
			next_r.tx_full = 1'b0;
			next_r.overrun = 1'b0;
			next_r.ier = RESET_BYTE;
		end
		if (r.syscfg[SC_FORCEOFF]) begin
			next_r.fifo_ctl[FC_ENABLE] = 1'b0;
		end

		// fast mode blocks chain on interrupt
		if (r.tweaks[MT_CHAIN]) begin
			next_r.chain = chain_enable_in_i & ~rx_int;
		end else if (!chain_enable_in_i) begin
			next_r.chain = 1'b0;
		end else if (interrupt_acknowledge_cycle_i && rx_int) begin
			next_r.chain = 1'b0;
		end else if (!rx_int) begin
			next_r.chain = 1'b1;
		end

		// ---- mpu read data
		unique case (mpu_addr_i)
			MPU_FIFO:   next_r.mpu_q = {r.fifo_ctl[7:6], r.chg_flag, r.txovr_flag,
				r.fifo_ctl[FC_DMA], r.rst_shadow, r.fifo_ctl[FC_ENABLE]};
			MPU_TXHOLD: next_r.mpu_q = r.tx_hold;
			MPU_SYSCFG: next_r.mpu_q = r.syscfg;
			MPU_MSTAT:  next_r.mpu_q = r.msr;
			MPU_SCR:    next_r.mpu_q = r.scratch;
			MPU_DIVLO:  next_r.mpu_q = r.div_lo;
			MPU_DIVHI:  next_r.mpu_q = r.div_hi;
			MPU_EVENTS: next_r.mpu_q = {5'h00, r.tx_full, r.overrun, r.div_evt};
			default:    next_r.mpu_q = 8'(UNMAPPED_READ);
		endcase
	end

	// ****************
	// registers
	// ****************
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r <= '0;
			r.s_rd <= 3'h7;
			r.s_wr <= 3'h7;
			r.s_cs <= 3'h7;
			r.chain <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ****************
	// outputs
	// ****************
	assign host_data_bus_o    = r.host_q;
	assign host_data_bus_oe_o = hsel & ~r.s_rd[2];
	// rx interrupt, no extra register stage
	assign host_intr_o        = rx_int & r.syscfg[SC_HOSTMODE];
	assign mpu_rdata_o        = r.mpu_q;
	assign dma_mode_o         = r.fifo_ctl[FC_DMA] & r.fifo_ctl[FC_ENABLE];
	assign mpu_intr_o         = r.div_evt | r.chg_flag | r.txovr_flag | r.tx_full;
	assign chain_enable_out_o = r.chain;

	// ****************
	// assertions
	// ****************
	a_msr_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		hrd_pulse && host_addr_i == HOST_MSTAT && m_tog == 4'h0 |=> r.msr[3:0] == 4'h0)
		else $error("modem deltas not cleared");
	a_ring_edge: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		$fell(r.msr[6]) |=> r.msr[2]) else $error("ring edge missed");
	a_dcd_delta: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		r.msr[7] != $past(r.msr[7]) |=> r.msr[3]) else $error("carrier delta missed");
	a_fifo_clr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		mpu_rd_i && mpu_addr_i == MPU_FIFO && !hwr_pulse && !r.tx_full |=>
		!r.chg_flag && !r.txovr_flag) else $error("fifo flags not cleared");
	a_self_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		r.fifo_ctl[FC_TXRST] |=> !r.fifo_ctl[FC_TXRST] || hwr_pulse)
		else $error("tx reset not self clearing");
	a_rx_flush: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		r.fifo_ctl[FC_RXRST] |-> r.rx_cnt == '0) else $error("rx not flushed");
	a_force_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		r.syscfg[SC_FORCEOFF] |=> !r.fifo_ctl[FC_ENABLE]) else $error("fifo not forced off");
	a_chain_fast: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		r.tweaks[MT_CHAIN] && rx_int |=> !chain_enable_out_o) else $error("chain not dropped");
	a_dma_mode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		dma_mode_o |-> r.fifo_ctl[FC_ENABLE]) else $error("dma mode without fifo");
	c_div_write: cover property (@(posedge ref_clk_i) r.div_evt);
	c_overrun:   cover property (@(posedge ref_clk_i) r.overrun && r.tweaks[MT_OVRWR]);
	c_rx_int:    cover property (@(posedge ref_clk_i) $rose(host_intr_o));
endmodule
`default_nettype wire

// ---- verification/hue_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// host side of the parallel port
// ****
module hue_host_model (
	// clock
	input  wire logic       ref_clk_i,
	// host pins
	output logic      [2:0] host_addr_o,
	output logic            host_select_n_o,
	output logic            host_read_strobe_n_o,
	output logic            host_write_strobe_n_o,
	output logic      [7:0] host_data_bus_o,
	input  wire logic [7:0] host_data_bus_i
);
	initial begin
		host_addr_o = 3'h0;
		host_select_n_o = 1'b1;
		host_read_strobe_n_o = 1'b1;
		host_write_strobe_n_o = 1'b1;
		host_data_bus_o = 8'h00;
	end
	// strobe held 6 clocks: the port needs 2 to sync and 1 to answer
	task automatic cycle(input logic [2:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk_i);
		#1;
		host_addr_o = a;
		host_select_n_o = 1'b0;
		host_data_bus_o = d;
		host_write_strobe_n_o = !w;
		host_read_strobe_n_o = w;
		repeat (6) @(posedge ref_clk_i);
		q = host_data_bus_i;
		#1;
		host_select_n_o = 1'b1;
		host_read_strobe_n_o = 1'b1;
		host_write_strobe_n_o = 1'b1;
		// released bus must not keep showing the written byte
		host_data_bus_o = ~d;
		repeat (4) @(posedge ref_clk_i);
	endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import hue_pkg::*;
	// ****
	// signals
	// ****
	logic       clk, rst, hsel_n, hrd_n, hwr_n, h_oe, h_int, m_rd, m_wr;
	logic       m_int, dma, c_in, ack, c_out, seen_int;
	logic [2:0] ha;
	logic [7:0] hd_host, hd_dut, hbus, m_a, m_wd, m_rdat, q;
	int         err_total, samples_checked;
	assign hbus = h_oe ? hd_dut : hd_host;
	hue_regs #(.DEPTH(16)) DUT (.ref_clk_i(clk), .reset_i(rst), .host_addr_i(ha),
		.host_select_n_i(hsel_n), .host_read_strobe_n_i(hrd_n),
		.host_write_strobe_n_i(hwr_n), .host_data_bus_i(hbus), .host_data_bus_o(hd_dut),
		.host_data_bus_oe_o(h_oe), .host_intr_o(h_int), .mpu_addr_i(m_a),
		.mpu_rd_i(m_rd), .mpu_wr_i(m_wr), .mpu_wdata_i(m_wd), .mpu_rdata_o(m_rdat),
		.mpu_intr_o(m_int), .dma_mode_o(dma), .chain_enable_in_i(c_in),
		.interrupt_acknowledge_cycle_i(ack), .chain_enable_out_o(c_out));
	hue_host_model host (.ref_clk_i(clk), .host_addr_o(ha), .host_select_n_o(hsel_n),
		.host_read_strobe_n_o(hrd_n), .host_write_strobe_n_o(hwr_n),
		.host_data_bus_o(hd_host), .host_data_bus_i(hbus));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// divisor events are one-cycle pulses, so catch them here
	always @(posedge clk) if (m_int) seen_int <= 1'b1;
	// ****
	// helpers
	// ****
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic mw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		m_a = a;
		m_wd = d;
		m_wr = 1'b1;
		@(posedge clk);
		#1;
		m_wr = 1'b0;
	endtask
	task automatic mr(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		m_a = a;
		m_rd = 1'b1;
		@(posedge clk);
		#1;
		m_rd = 1'b0;
		d = m_rdat;
	endtask
	task automatic hw(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.cycle(a, 1'b1, d, x);
	endtask
	task automatic hr(input logic [2:0] a, output logic [7:0] d);
		host.cycle(a, 1'b0, 8'h00, d);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_mode();
		hw(HOST_SCR, 8'h5a);
		mr(MPU_SCR, q);
		check(q, RESET_BYTE);
		mw(MPU_SYSCFG, 8'h02);
		seen_int = 1'b0;
		hw(HOST_SCR, 8'h3c);
		mr(MPU_SCR, q);
		check(q, 8'h3c);
		check({7'h0, seen_int}, 8'h00);
		$display("test mode done");
	endtask
	task automatic t_div();
		hw(HOST_LINE, 8'h80);
		seen_int = 1'b0;
		hw(HOST_DATA, 8'h12);
		check({7'h0, seen_int}, 8'h01);
		seen_int = 1'b0;
		hw(HOST_IER, 8'h34);
		check({7'h0, seen_int}, 8'h01);
		mr(MPU_DIVLO, q);
		check(q, 8'h12);
		hr(HOST_DATA, q);
		check(q, 8'h12);
		hw(HOST_LINE, 8'h03);
		hw(HOST_IER, 8'h00);
		mr(MPU_DIVHI, q);
		check(q, 8'h34);
		$display("test divisor done");
	endtask
	task automatic t_fifo();
		hw(HOST_FIFO, 8'hc8);
		mr(MPU_FIFO, q);
		check(q & 8'hc9, 8'h00);
		hw(HOST_FIFO, 8'hcf);
		mr(MPU_FIFO, q);
		check(q, 8'hef);
		check({7'h0, dma}, 8'h01);
		mr(MPU_FIFO, q);
		check(q, 8'hc9);
		$display("test fifo control done");
	endtask
	task automatic t_trig();
		int lvl[4] = '{1, 4, 8, 14};
		hw(HOST_IER, 8'h01);
		for (int i = 0; i < 4; i++) begin
			hw(HOST_FIFO, {i[1:0], 6'h03});
			for (int n = 1; n <= lvl[i]; n++) begin
				mw(MPU_RXBUF, n[7:0]);
				@(posedge clk);
				check({7'h0, h_int}, {7'h0, n >= lvl[i]});
			end
			hr(HOST_DATA, q);
			check(q, 8'h01);
			check({7'h0, h_int}, 8'h00);
		end
		$display("test trigger done");
	endtask
	task automatic t_ovr();
		for (int m = 0; m < 2; m++) begin
			mw(MPU_TWEAKS, {6'h0, m[0], 1'b0});
			hw(HOST_FIFO, 8'h03);
			for (int k = 0; k < 16; k++) mw(MPU_RXBUF, k[7:0]);
			mw(MPU_RXBUF, 8'haa);
			mw(MPU_RXBUF, 8'hbb);
			for (int k = 0; k < 16; k++) begin
				hr(HOST_DATA, q);
				check(q, (k == 15 && m == 1) ? 8'hbb : k[7:0]);
			end
		end
		$display("test overrun done");
	endtask
	task automatic t_modem();
		mw(MPU_MSTAT, 8'hf0);
		hr(HOST_MSTAT, q);
		check(q, 8'hfb);
		hr(HOST_MSTAT, q);
		check(q, 8'hf0);
		mw(MPU_MSTAT, 8'h00);
		hr(HOST_MSTAT, q);
		check(q, 8'h0f);
		$display("test modem done");
	endtask
	task automatic t_chain();
		mr(MPU_FIFO, q);
		for (int m = 0; m < 2; m++) begin
			mw(MPU_TWEAKS, {7'h0, m == 0});
			// a received byte raises the host interrupt that the chain watches
			mw(MPU_RXBUF, 8'h55);
			@(posedge clk);
			#1;
			check({7'h0, c_out}, m[7:0]);
			if (m == 1) begin
				ack = 1'b1;
				@(posedge clk);
				#1;
				ack = 1'b0;
				repeat (2) @(posedge clk);
				check({7'h0, c_out}, 8'h00);
			end
			hr(HOST_DATA, q);
			check(q, 8'h55);
			hw(HOST_DATA, 8'h55);
			mr(MPU_TXHOLD, q);
			check(q, 8'h55);
			repeat (2) @(posedge clk);
			check({6'h0, c_out, m_int}, 8'h02);
		end
		$display("test chain done");
	endtask
	task automatic t_flush();
		mw(MPU_RXBUF, 8'h11);
		hw(HOST_FIFO, 8'h00);
		hr(HOST_LSTAT, q);
		check(q & 8'h01, 8'h00);
		hr(HOST_IER, q);
		check(q, 8'h00);
		mw(MPU_SYSCFG, 8'h0a);
		hw(HOST_FIFO, 8'h01);
		mr(MPU_FIFO, q);
		check(q & 8'h01, 8'h00);
		$display("test flush done");
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		err_total = 0;
		samples_checked = 0;
		rst = 1'b1;
		m_a = 8'h00;
		m_wd = 8'h00;
		m_rd = 1'b0;
		m_wr = 1'b0;
		c_in = 1'b1;
		ack = 1'b0;
		seen_int = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		t_mode();
		t_div();
		t_fifo();
		t_trig();
		t_ovr();
		t_modem();
		t_chain();
		t_flush();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		end_of_test();
	end
endmodule
`default_nettype wire
